//--- src/dcw_pkg.sv
// Constants shared by the division chain watchdog block
package dcw_pkg;
  localparam int CLK_MHZ         = 40;
  localparam int WD_TIMEOUT_US   = 200;
  localparam int WD_CYCLES       = WD_TIMEOUT_US * CLK_MHZ;
  localparam int LINK_TIMEOUT_US = 20;
  localparam int LINK_TO_CYCLES  = LINK_TIMEOUT_US * CLK_MHZ;
  localparam int NUM_DET         = 52;
  localparam int NUM_STAGES      = 3;
  localparam int STAGE_CYCLES    = 4;
  localparam int MSG_WORDS       = 4;
  localparam int CAL_ITEMS       = 4;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] WDCNT_OFF  = 8'h08;
  localparam logic [7:0] AVG_OFF    = 8'h0c;
  localparam logic [7:0] CALPND_OFF = 8'h10;
  localparam logic [7:0] CALTAB_OFF = 8'h14;
  // Control fields
  localparam int CTRL_WD_FORCE  = 0;
  localparam int CTRL_CLR       = 1;
  localparam int CTRL_STALL_LSB = 4;
  // Status fields
  localparam int ST_FAILED   = 0;
  localparam int ST_WD_EXP   = 1;
  localparam int ST_DATA_ERR = 2;
  localparam int ST_TO_ERR   = 3;
  localparam int ST_CAL_REJ  = 4;
  localparam int ST_CAL_PEND = 5;
  localparam int ST_CAL_GATE = 6;
  localparam int ST_TRIP     = 7;
  localparam int ST_BUSY_LSB = 8;
  // Message and calibration formats
  localparam logic [7:0]  MSG_HDR  = 8'ha5;
  localparam logic [7:0]  CAL_TAG  = 8'hc3;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // Calibration table entries: 0 average trip level, 1 startup flux level, 2 shortest period
  localparam logic [15:0] CAL0_RST = 16'h0c00;
  localparam logic [15:0] CAL1_RST = 16'h0800;
  localparam logic [15:0] CAL2_RST = 16'h0010;
  localparam logic [15:0] CAL3_RST = 16'h0000;
endpackage : dcw_pkg

//--- src/dcw_top.sv
// Division chain watchdog: detector intake, stage chain, watchdog, votes, calibration gate, AXI4-Lite registers
// Notes on behaviour
// - A stage idles until the previous stage hands it data.
// - A stage forwards results only when its computation has finished.
// - Last stage hand-off clears the watchdog and restarts its interval.
// - A stage that never finishes leaves every later stage unstarted.
// - Watchdog expiry flags the module failed, trips the division, raises alarm.
// - Software can force expiry and read the watchdog count for testing.
// - All state changes on rising edges of the single clock.
// - Outgoing messages are fixed length and format, sent after the last stage.
// - Detector link words are checked for data errors and arrival timeout.
// - Every detected error drives the operator alarm output.
// - A communication failure asserts the module failure indication.
// - No interrupts or event scheduling; only the fixed clocked sequence.
// - The averaging path accepts readings from 52 detector channels.
// - Detector links are receive-only here, with no return path.
// - Averaging trip drives one discrete vote-to-trip output.
// - Startup monitor votes trip on high flux or short period.
// - No path to other divisions; voting is done downstream.
// - Calibration intake blocked unless bypassed, inoperative and key enabled.
// - Only tagged items with valid index are accepted, others rejected.
// - Calibration items apply only after operator confirms each one.
`timescale 1ns/1ps
module dcw_top #(
  parameter int WD_CYCLES = dcw_pkg::WD_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        det_valid,
  input  wire logic [5:0]  det_chan,
  input  wire logic [15:0] det_data,
  input  wire logic        det_parity,
  input  wire logic [15:0] srm_flux,
  input  wire logic [15:0] srm_period,
  output logic             vote_trip_avg,
  output logic             vote_trip_srm,
  output logic             module_failed,
  output logic             operator_alarm,
  output logic             tx_valid,
  output logic [31:0]      tx_word,
  input  wire logic        bypass_in,
  input  wire logic        inoperative_in,
  input  wire logic        key_enable_in,
  input  wire logic        cal_valid,
  input  wire logic [31:0] cal_word,
  input  wire logic        op_accept,
  input  wire logic        op_reject
);
  import dcw_pkg::*;

  logic [31:0]           ctrl_reg;
  logic                  wd_force;
  logic                  err_clear;
  logic [NUM_STAGES-1:0] stall_mask;
  logic [NUM_STAGES-1:0] stage_busy;
  logic [NUM_STAGES-1:0] stage_done;
  logic [NUM_STAGES-1:0] stage_start;
  logic [1:0]            stage_cnt [NUM_STAGES];
  logic [5:0]            word_cnt;
  logic [21:0]           sum_reg;
  logic                  frame_bad;
  logic                  pass_start;
  logic                  word_err;
  logic [9:0]            to_cnt;
  logic                  data_err_reg;
  logic                  to_err_reg;
  logic [13:0]           wd_cnt;
  logic                  wd_exp_reg;
  logic                  failed_reg;
  logic [15:0]           avg_reg;
  logic                  trip_reg;
  logic [1:0]            tx_idx;
  logic                  cal_gate;
  logic                  cal_pend_reg;
  logic [1:0]            cal_idx_reg;
  logic [15:0]           cal_val_reg;
  logic                  cal_rej_reg;
  logic [15:0]           cal_tab [CAL_ITEMS];
  logic                  aw_hold;
  logic                  w_hold;
  logic [7:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  wr_fire;
  logic [31:0]           rd_val;
  logic                  rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Detector link receiver
  // Links are receive-only; nothing flows back to the detectors
  assign word_err = det_valid && ((^{det_data, det_parity}) || (det_chan != word_cnt));
  assign pass_start = det_valid && !word_err && !frame_bad &&
                      (word_cnt == 6'(NUM_DET - 1)) && !stage_busy[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_cnt  <= 6'h00;
      sum_reg   <= 22'h000000;
      frame_bad <= 1'b0;
    end else if (det_valid) begin
      if (word_cnt == 6'(NUM_DET - 1)) begin
        word_cnt  <= 6'h00;
        sum_reg   <= 22'h000000;
        frame_bad <= 1'b0;
      end else begin
        word_cnt  <= word_cnt + 6'h01;
        sum_reg   <= sum_reg + 22'(det_data);
        frame_bad <= frame_bad | word_err;
      end
    end
  end

  // Final word is folded in when frame_sum is captured on pass_start, so the running sum excludes it
  logic [21:0] frame_sum;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_sum <= 22'h000000;
    end else if (pass_start) begin
      frame_sum <= sum_reg + 22'(det_data);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_cnt     <= 10'h000;
      to_err_reg <= 1'b0;
    end else if (det_valid) begin
      to_cnt     <= 10'h000;
      to_err_reg <= to_err_reg & ~err_clear;
    end else if (to_cnt == 10'(LINK_TO_CYCLES - 1)) begin
      to_cnt     <= 10'h000;
      to_err_reg <= 1'b1;
    end else begin
      to_cnt     <= to_cnt + 10'h001;
      to_err_reg <= to_err_reg & ~err_clear;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_err_reg <= 1'b0;
    end else begin
      data_err_reg <= word_err | (data_err_reg & ~err_clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage chain
  genvar g;
  generate
    for (g = 0; g < NUM_STAGES; g++) begin : g_stage
      if (g == 0) begin : g_first
        assign stage_start[g] = pass_start;
      end else begin : g_next
        assign stage_start[g] = stage_done[g-1];
      end
      // A stalled stage holds its count and its done is masked, so nothing downstream starts
      assign stage_done[g] = stage_busy[g] && !stall_mask[g] &&
                             (stage_cnt[g] == 2'(STAGE_CYCLES - 1));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stage_busy[g] <= 1'b0;
          stage_cnt[g]  <= 2'h0;
        end else if (stage_start[g] && !stage_busy[g]) begin
          stage_busy[g] <= 1'b1;
          stage_cnt[g]  <= 2'h0;
        end else if (stage_done[g]) begin
          stage_busy[g] <= 1'b0;
        end else if (stage_busy[g] && !stall_mask[g]) begin
          stage_cnt[g]  <= stage_cnt[g] + 2'h1;
        end
      end
    end
  endgenerate

  // Results leave a stage only on its done cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avg_reg  <= 16'h0000;
      trip_reg <= 1'b0;
    end else begin
      if (stage_done[0]) begin
        avg_reg <= 16'(frame_sum / 22'(NUM_DET));
      end
      if (stage_done[1]) begin
        trip_reg <= (avg_reg > cal_tab[0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt     <= 14'h0000;
      wd_exp_reg <= 1'b0;
    end else if (stage_done[NUM_STAGES-1]) begin
      wd_cnt     <= 14'h0000;
      // A forced expiry must stay visible even when a pass completes in the same cycle
      wd_exp_reg <= wd_force | (wd_exp_reg & ~err_clear);
    end else if (wd_force || wd_cnt == 14'(WD_CYCLES - 1)) begin
      wd_cnt     <= 14'h0000;
      wd_exp_reg <= 1'b1;
    end else begin
      wd_cnt     <= wd_cnt + 14'h0001;
      wd_exp_reg <= wd_exp_reg & ~err_clear;
    end
  end

  // Clear only takes effect once the cause is gone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      failed_reg <= 1'b0;
    end else if ((wd_force || wd_cnt == 14'(WD_CYCLES - 1)) || word_err ||
                 (!det_valid && to_cnt == 10'(LINK_TO_CYCLES - 1))) begin
      failed_reg <= 1'b1;
    end else if (err_clear) begin
      failed_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Discrete outputs; fail-safe: a failed module votes trip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vote_trip_avg  <= 1'b0;
      vote_trip_srm  <= 1'b0;
      module_failed  <= 1'b0;
      operator_alarm <= 1'b0;
    end else begin
      vote_trip_avg  <= trip_reg | failed_reg;
      vote_trip_srm  <= (srm_flux > cal_tab[1]) || (srm_period < cal_tab[2]) || failed_reg;
      module_failed  <= failed_reg;
      operator_alarm <= failed_reg | wd_exp_reg | data_err_reg | to_err_reg | cal_rej_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing fixed message, started by the last stage hand-off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid <= 1'b0;
      tx_idx   <= 2'h0;
      tx_word  <= 32'h00000000;
    end else if (stage_done[NUM_STAGES-1]) begin
      tx_valid <= 1'b1;
      tx_idx   <= 2'h1;
      tx_word  <= {MSG_HDR, 8'h00, 16'(NUM_DET)};
    end else if (tx_valid) begin
      tx_idx <= tx_idx + 2'h1;
      case (tx_idx)
        2'h1: tx_word <= {16'h0000, avg_reg};
        2'h2: tx_word <= {28'h0000000, to_err_reg, data_err_reg, failed_reg, trip_reg};
        2'h3: tx_word <= {MSG_HDR, 8'h00, avg_reg ^ {12'h000, to_err_reg, data_err_reg, failed_reg, trip_reg}};
        default: begin
          tx_valid <= 1'b0;
          tx_word  <= 32'h00000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration intake
  assign cal_gate = bypass_in && inoperative_in && key_enable_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_pend_reg <= 1'b0;
      cal_idx_reg  <= 2'h0;
      cal_val_reg  <= 16'h0000;
      cal_rej_reg  <= 1'b0;
    end else if (cal_gate) begin
      if (cal_valid && !cal_pend_reg && cal_word[31:24] == CAL_TAG &&
          cal_word[23:16] < 8'(CAL_ITEMS)) begin
        cal_pend_reg <= 1'b1;
        cal_idx_reg  <= cal_word[17:16];
        cal_val_reg  <= cal_word[15:0];
      end else if (op_accept || op_reject) begin
        cal_pend_reg <= 1'b0;
      end
      cal_rej_reg <= (cal_valid && (cal_pend_reg || cal_word[31:24] != CAL_TAG ||
                      cal_word[23:16] >= 8'(CAL_ITEMS))) || (cal_rej_reg & ~err_clear);
    end else begin
      cal_rej_reg <= cal_rej_reg & ~err_clear;
    end
  end

  generate
    for (g = 0; g < CAL_ITEMS; g++) begin : g_cal
      localparam logic [15:0] RST = (g == 0) ? CAL0_RST : (g == 1) ? CAL1_RST :
                                    (g == 2) ? CAL2_RST : CAL3_RST;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cal_tab[g] <= RST;
        end else if (cal_gate && op_accept && cal_pend_reg && cal_idx_reg == 2'(g)) begin
          cal_tab[g] <= cal_val_reg;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;
  assign wd_force      = wr_fire && aw_addr == CTRL_OFF && w_strb[0] && w_data[CTRL_WD_FORCE];
  assign err_clear     = wr_fire && aw_addr == CTRL_OFF && w_strb[0] && w_data[CTRL_CLR];
  assign stall_mask    = ctrl_reg[CTRL_STALL_LSB +: NUM_STAGES];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
    end
  end

  // Force and clear bits are pulses and never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg    <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == CTRL_OFF) ? RESP_OKAY : RESP_SLVERR;
      if (aw_addr == CTRL_OFF && w_strb[0]) begin
        ctrl_reg[7:0] <= w_data[7:0] & 8'hfc;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CTRL_OFF:   rd_val = ctrl_reg;
      STATUS_OFF: rd_val = {21'h000000, stage_busy, trip_reg, cal_gate, cal_pend_reg, cal_rej_reg,
                            to_err_reg, data_err_reg, wd_exp_reg, failed_reg};
      WDCNT_OFF:  rd_val = {18'h00000, wd_cnt};
      AVG_OFF:    rd_val = {16'h0000, avg_reg};
      CALPND_OFF: rd_val = {14'h0000, cal_idx_reg, cal_val_reg};
      default: begin
        if (s_axi_araddr >= CALTAB_OFF && s_axi_araddr < CALTAB_OFF + 8'(4 * CAL_ITEMS) &&
            s_axi_araddr[1:0] == 2'h0) begin
          rd_val = {16'h0000, cal_tab[2'(s_axi_araddr[7:2] - CALTAB_OFF[7:2])]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_stage_order;
    @(posedge aclk) disable iff (!aresetn) $rose(stage_busy[1]) |-> $past(stage_done[0]);
  endproperty
  a_stage_order: assert property (p_stage_order) else $error("Stage 1 started without hand-off");

  property p_fwd_done;
    @(posedge aclk) disable iff (!aresetn) $changed(avg_reg) |-> $past(stage_done[0]);
  endproperty
  a_fwd_done: assert property (p_fwd_done) else $error("Average changed before stage finished");

  property p_wd_restart;
    @(posedge aclk) disable iff (!aresetn) stage_done[NUM_STAGES-1] |=> wd_cnt == 14'h0000 ##1 wd_cnt == 14'h0001;
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("Watchdog did not restart after pass");

  property p_stall_blocks;
    @(posedge aclk) disable iff (!aresetn) stall_mask[1] && stage_busy[1] && !stage_busy[2] |=> !stage_busy[2];
  endproperty
  a_stall_blocks: assert property (p_stall_blocks) else $error("Stage started after stalled stage");

  property p_wd_fail;
    @(posedge aclk) disable iff (!aresetn)
      wd_cnt == 14'(WD_CYCLES - 1) && !stage_done[NUM_STAGES-1] |=> failed_reg ##1 (module_failed && vote_trip_avg && operator_alarm);
  endproperty
  a_wd_fail: assert property (p_wd_fail) else $error("Watchdog expiry did not fail and trip");

  property p_force;
    @(posedge aclk) disable iff (!aresetn) wd_force |=> wd_exp_reg && wd_cnt == 14'h0000;
  endproperty
  a_force: assert property (p_force) else $error("Forced expiry not seen");

  property p_msg;
    @(posedge aclk) disable iff (!aresetn)
      $rose(tx_valid) |-> tx_word[31:24] == MSG_HDR ##1 tx_valid [*3] ##1 !tx_valid;
  endproperty
  a_msg: assert property (p_msg) else $error("Outgoing message length or header wrong");

  property p_link_to;
    @(posedge aclk) disable iff (!aresetn) !det_valid && to_cnt == 10'(LINK_TO_CYCLES - 1) |=> to_err_reg && failed_reg;
  endproperty
  a_link_to: assert property (p_link_to) else $error("Link timeout not flagged");

  property p_cal_block;
    @(posedge aclk) disable iff (!aresetn) !cal_gate |=> $stable(cal_pend_reg) && $stable(cal_val_reg);
  endproperty
  a_cal_block: assert property (p_cal_block) else $error("Calibration taken while blocked");

  property p_cal_apply;
    @(posedge aclk) disable iff (!aresetn) $changed(cal_tab[0]) |-> $past(op_accept && cal_pend_reg && cal_gate);
  endproperty
  a_cal_apply: assert property (p_cal_apply) else $error("Calibration applied without confirmation");

endmodule : dcw_top

//--- tb/dcw_det_source.sv
// Detector link source model: frames of 52 words every 60 cycles with optional parity fault
`timescale 1ns/1ps
module dcw_det_source (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  input  wire logic        corrupt,
  output logic             det_valid,
  output logic [5:0]       det_chan,
  output logic [15:0]      det_data,
  output logic             det_parity
);
  logic [5:0] pos_reg;
  logic       live;
  assign live = run && pos_reg < 6'h34;
  // Transmit only: nothing comes back from the averaging unit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_reg    <= 6'h00;
      det_valid  <= 1'b0;
      det_chan   <= 6'h00;
      det_data   <= 16'h0000;
      det_parity <= 1'b0;
    end else begin
      // Position holds at zero while stopped so a frame never starts mid-way
      pos_reg   <= (!run || pos_reg == 6'h3b) ? 6'h00 : pos_reg + 6'h01;
      det_valid <= live;
      det_chan  <= pos_reg;
      if (live) begin
        det_data   <= {9'h000, pos_reg, 1'b0};
        det_parity <= ^pos_reg ^ (corrupt && pos_reg == 6'h0a);
      end else begin
        // Released lines keep toggling so stale data is never mistaken for valid
        det_data   <= ~det_data;
        det_parity <= ~det_parity;
      end
    end
  end
endmodule : dcw_det_source

//--- tb/division_chain_watchdog_test.sv
// Testbench for the division chain watchdog block
`timescale 1ns/1ps
module division_chain_watchdog_test;
  import dcw_pkg::*;
  localparam int WD = 200;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic        dv, dp, vta, vts, mfail, alarm, tx_valid, bypass, inop, key, cv, acc, rej, run, corrupt;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, tx_word, cal_word;
  logic [1:0]  bresp, rresp;
  logic [5:0]  dch;
  logic [15:0] dd, srm_flux, srm_period, avg;
  int          n_mismatch, checks, sum;
  dcw_top #(.WD_CYCLES(WD)) dcw_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .det_valid(dv), .det_chan(dch), .det_data(dd), .det_parity(dp), .srm_flux(srm_flux),
    .srm_period(srm_period), .vote_trip_avg(vta), .vote_trip_srm(vts), .module_failed(mfail),
    .operator_alarm(alarm), .tx_valid(tx_valid), .tx_word(tx_word), .bypass_in(bypass), .inoperative_in(inop),
    .key_enable_in(key), .cal_valid(cv), .cal_word(cal_word), .op_accept(acc), .op_reject(rej));
  dcw_det_source dcw_det_source_i (.aclk(aclk), .aresetn(aresetn), .run(run), .corrupt(corrupt),
    .det_valid(dv), .det_chan(dch), .det_data(dd), .det_parity(dp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string s);
    $display("unexpected at %0t: %s", $time, s);
    n_mismatch++;
  endtask : fail
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) fail($sformatf("got %h expected %h", g, e));
  endtask : cmp32
  task automatic cmp1(input logic g, input logic e);
    checks++;
    if (g !== e) fail($sformatf("flag %b expected %b", g, e));
  endtask : cmp1
  task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (!bvalid) fail("no write response");
    cmp32({30'h0, bresp}, {30'h0, er});
  endtask : wrchk
  // Read data is masked so that fields outside the point of a check are ignored
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (!rvalid) fail("no read response");
    cmp32(rdata & m, e);
    cmp32({30'h0, rresp}, {30'h0, er});
  endtask : rdchk
  // Kind bits: reject, accept, item valid
  task automatic cal(input logic [31:0] w, input logic [2:0] k);
    cal_word <= w;
    cv <= k[0];
    acc <= k[1];
    rej <= k[2];
    @(posedge aclk);
    cv <= 1'b0;
    acc <= 1'b0;
    rej <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : cal
  task automatic msg(input logic [3:0] f);
    int n;
    logic [31:0] e [4];
    e = '{{MSG_HDR, 8'h00, 16'(NUM_DET)}, {16'h0000, avg}, {28'h0, f}, {MSG_HDR, 8'h00, avg ^ {12'h000, f}}};
    n = 0;
    while (tx_valid && n < 8) begin
      @(posedge aclk);
      n++;
    end
    do begin
      @(posedge aclk);
      n++;
    end while (!tx_valid && n < 200);
    for (int i = 0; i < 4; i++) begin
      cmp1(tx_valid, 1'b1);
      cmp32(tx_word, e[i]);
      @(posedge aclk);
    end
  endtask : msg
  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    #(25 * 20000);
    fail("watchdog ran out");
    finish_test();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, bypass, inop, key, cv, acc, rej, run, corrupt} = '0;
    {awaddr, araddr, wdata, cal_word, srm_flux} = '0;
    srm_period = 16'hffff;
    sum = 0;
    for (int i = 0; i < NUM_DET; i++) sum += 2 * i;
    avg = 16'(sum / NUM_DET);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    @(posedge aclk);
    rdchk(STATUS_OFF, 32'h7ff, 32'h0, RESP_OKAY);
    rdchk(CALTAB_OFF, 32'hffffffff, {16'h0, CAL0_RST}, RESP_OKAY);
    rdchk(8'h40, 32'hffffffff, 32'h0, RESP_SLVERR);
    wrchk(WDCNT_OFF, 32'h0, RESP_SLVERR);
    msg(4'h0);
    rdchk(WDCNT_OFF, 32'hffffffc0, 32'h0, RESP_OKAY);
    cmp1(vts, 1'b0);
    srm_flux <= CAL1_RST + 16'h1;
    repeat (3) @(posedge aclk);
    cmp1(vts, 1'b1);
    srm_flux <= CAL1_RST;
    srm_period <= CAL2_RST - 16'h1;
    repeat (3) @(posedge aclk);
    cmp1(vts, 1'b1);
    srm_period <= CAL2_RST;
    repeat (3) @(posedge aclk);
    cmp1(vts, 1'b0);
    bypass <= 1'b1;
    inop <= 1'b1;
    cal({CAL_TAG, 8'h00, 16'h0020}, 3'b001);
    rdchk(STATUS_OFF, 32'h70, 32'h0, RESP_OKAY);
    key <= 1'b1;
    cal({8'h3c, 8'h00, 16'h0020}, 3'b001);
    rdchk(STATUS_OFF, 32'h70, 32'h50, RESP_OKAY);
    cmp1(alarm, 1'b1);
    wrchk(CTRL_OFF, 32'h2, RESP_OKAY);
    rdchk(STATUS_OFF, 32'h70, 32'h40, RESP_OKAY);
    cal({CAL_TAG, 8'h04, 16'h0020}, 3'b001);
    rdchk(STATUS_OFF, 32'h70, 32'h50, RESP_OKAY);
    cal({CAL_TAG, 8'h01, 16'h1234}, 3'b001);
    cal(32'h0, 3'b100);
    rdchk(CALTAB_OFF + 8'h04, 32'hffffffff, {16'h0, CAL1_RST}, RESP_OKAY);
    cal({CAL_TAG, 8'h00, 16'h0020}, 3'b001);
    rdchk(STATUS_OFF, 32'h20, 32'h20, RESP_OKAY);
    rdchk(CALTAB_OFF, 32'hffffffff, {16'h0, CAL0_RST}, RESP_OKAY);
    cal(32'h0, 3'b010);
    rdchk(CALTAB_OFF, 32'hffffffff, 32'h20, RESP_OKAY);
    key <= 1'b0;
    wrchk(CTRL_OFF, 32'h2, RESP_OKAY);
    repeat (70) @(posedge aclk);
    msg(4'h1);
    cmp1(vta, 1'b1);
    cmp1(mfail, 1'b0);
    cmp1(alarm, 1'b0);
    corrupt <= 1'b1;
    repeat (70) @(posedge aclk);
    corrupt <= 1'b0;
    rdchk(STATUS_OFF, 32'h5, 32'h5, RESP_OKAY);
    cmp1(alarm, 1'b1);
    cmp1(vts, 1'b1);
    msg(4'h7);
    wrchk(CTRL_OFF, 32'h2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp1(mfail, 1'b0);
    wrchk(CTRL_OFF, 32'h20, RESP_OKAY);
    repeat (WD + 70) @(posedge aclk);
    rdchk(STATUS_OFF, 32'h603, 32'h203, RESP_OKAY);
    cmp1(alarm, 1'b1);
    cmp1(vta, 1'b1);
    wrchk(CTRL_OFF, 32'h0, RESP_OKAY);
    msg(4'h3);
    wrchk(CTRL_OFF, 32'h2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp1(mfail, 1'b0);
    wrchk(CTRL_OFF, 32'h1, RESP_OKAY);
    rdchk(STATUS_OFF, 32'h3, 32'h3, RESP_OKAY);
    run <= 1'b0;
    repeat (LINK_TO_CYCLES + 20) @(posedge aclk);
    rdchk(STATUS_OFF, 32'h8, 32'h8, RESP_OKAY);
    finish_test();
  end
endmodule : division_chain_watchdog_test
